// File: hw/quad_dac_serial_pin_control.sv
// pin-level control of a four-channel voltage-output converter
// assumes pins are asynchronous to sys_clk and sclk is far slower than sys_clk
//
// Summary of operation
// - gain strap picks gain one or two
// - divider strap halves reference; later changes ignored
// - reset level pin picks zero or midscale
// - strobe fall updates synchronous channels together
// - strobe tied low never disturbs operation
// - shift register enabled only while chip-select low
// - data-in captured on falling sclk while chip-select low
// - data output floats while chip-select high, outside alarm mode
// - shift register out, edge chosen by bit
// - output pin optionally open-drain alarm
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_pin_control #(
   parameter int CHANNELS = quad_dac_pkg::CHANNELS,
   parameter int CODE_WIDTH = quad_dac_pkg::CODE_WIDTH
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   // serial pins
   input wire quad_dac_pkg::serial_pins_type serialPins,
   output logic sdoOut,
   output logic sdoOe,
   // strap and strobe pins
   input wire logic gainStrap,
   input wire logic referenceHalvingStrap,
   input wire logic resetLevelSelect,
   input wire logic loadStrobe,
   // configuration and alarm sources
   input wire logic outputEdgeSelect,
   input wire logic alarmMode,
   input wire logic [CHANNELS-1:0] syncMode,
   input wire logic crcFail,
   input wire logic refAlarm,
   // converter state
   output logic gainTwo,
   output logic refHalved,
   output logic [CHANNELS-1:0][CODE_WIDTH-1:0] chanCode
);
   localparam int FB = quad_dac_pkg::FRAME_BITS;

   logic [2:0] csSync_r, sclkSync_r, sdiSync_r, strobeSync_r;
   logic [1:0] gainSync_r, divSync_r, lvlSync_r;
   logic [1:0] settle_r;
   logic resetMid_r;
   logic [FB-1:0] shift_r;
   logic [quad_dac_pkg::CNT_WIDTH-1:0] bitCnt_r;
   logic [CHANNELS-1:0][CODE_WIDTH-1:0] buffer_r;
   logic csLow, sclkFall, sclkRise, csRise, csFall, strobeFall, writeStrobe, alarmNow;
   logic [1:0] writeChan;

   // pin synchronisers; only the later stages are read by logic
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         csSync_r <= 3'h7;
         sclkSync_r <= 3'h0;
         sdiSync_r <= 3'h0;
         strobeSync_r <= 3'h0; // low start: no false edge with pin tied low
         gainSync_r <= 2'h0;
         divSync_r <= 2'h0;
         lvlSync_r <= 2'h0;
      end else if (clkEn) begin
         csSync_r <= {csSync_r[1:0], serialPins.csB};
         sclkSync_r <= {sclkSync_r[1:0], serialPins.sclk};
         sdiSync_r <= {sdiSync_r[1:0], serialPins.sdi};
         strobeSync_r <= {strobeSync_r[1:0], loadStrobe};
         gainSync_r <= {gainSync_r[0], gainStrap};
         divSync_r <= {divSync_r[0], referenceHalvingStrap};
         lvlSync_r <= {lvlSync_r[0], resetLevelSelect};
      end
   end

   // edge detection on synchronised pins
   assign csLow = !csSync_r[1];
   assign csRise = csSync_r[1] && !csSync_r[2];
   assign csFall = !csSync_r[1] && csSync_r[2];
   assign sclkFall = !sclkSync_r[1] && sclkSync_r[2];
   assign sclkRise = sclkSync_r[1] && !sclkSync_r[2];
   assign strobeFall = !strobeSync_r[1] && strobeSync_r[2];
   assign writeStrobe = csRise && (bitCnt_r == quad_dac_pkg::CNT_WIDTH'(FB));
   assign writeChan = shift_r[quad_dac_pkg::FRAME_CHAN_LSB +: 2];
   assign alarmNow = crcFail || refAlarm;

   // straps are taken once, after the synchronisers have filled
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         settle_r <= quad_dac_pkg::STRAP_SETTLE_CYCLES;
         gainTwo <= 1'b0;
         refHalved <= 1'b0;
         resetMid_r <= 1'b0;
      end else if (clkEn && settle_r != 2'h0) begin
         settle_r <= settle_r - 2'h1;
         if (settle_r == quad_dac_pkg::STRAP_TAKE_CYCLE) begin
            gainTwo <= gainSync_r[1];
            refHalved <= divSync_r[1]; // later strap moves never reach here
            resetMid_r <= lvlSync_r[1];
         end
      end
   end

   // input shift register, live only inside a frame
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         shift_r <= '0;
         bitCnt_r <= '0;
      end else if (clkEn) begin
         if (csFall) begin
            bitCnt_r <= '0;
         end else if (csLow && sclkFall) begin
            shift_r <= {shift_r[FB-2:0], sdiSync_r[1]};
            if (bitCnt_r != '1) begin
               bitCnt_r <= bitCnt_r + 1'b1;
            end
         end
      end
   end

   // data-out pin: serial data or open-drain alarm
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         sdoOut <= 1'b0;
         sdoOe <= 1'b0;
      end else if (clkEn) begin
         if (alarmMode) begin
            sdoOut <= 1'b0; // only ever pulls low
            sdoOe <= alarmNow;
         end else begin
            sdoOe <= csLow && !csFall;
            if (csFall) begin
               sdoOut <= shift_r[FB-1];
            end else if (csLow && outputEdgeSelect && sclkFall) begin
               sdoOut <= shift_r[FB-2];
            end else if (csLow && !outputEdgeSelect && sclkRise) begin
               sdoOut <= shift_r[FB-1];
            end
         end
      end
   end

   // per-channel buffer and output code
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      always_ff @(posedge sys_clk) begin
         if (!rst_b) begin
            buffer_r[ch] <= quad_dac_pkg::ZERO_SCALE_CODE;
            chanCode[ch] <= quad_dac_pkg::ZERO_SCALE_CODE;
         end else if (clkEn) begin
            if (settle_r == quad_dac_pkg::STRAP_TAKE_CYCLE) begin
               buffer_r[ch] <= lvlSync_r[1] ? quad_dac_pkg::MID_SCALE_CODE
                  : quad_dac_pkg::ZERO_SCALE_CODE;
               chanCode[ch] <= lvlSync_r[1] ? quad_dac_pkg::MID_SCALE_CODE
                  : quad_dac_pkg::ZERO_SCALE_CODE;
            end else begin
               if (writeStrobe && writeChan == 2'(ch)) begin
                  buffer_r[ch] <= shift_r[quad_dac_pkg::FRAME_CODE_LSB +: CODE_WIDTH];
               end
               if (writeStrobe && writeChan == 2'(ch) && !syncMode[ch]) begin
                  chanCode[ch] <= shift_r[quad_dac_pkg::FRAME_CODE_LSB +: CODE_WIDTH];
               end else if (syncMode[ch] && strobeFall) begin
                  chanCode[ch] <= buffer_r[ch];
               end
            end
         end
      end
   end

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   gain_strap_a: assert property (clkEn && settle_r == 2'h1 |=> gainTwo == $past(gainSync_r[1]))
      else $error("gain not taken from strap");
   div_hold_a: assert property (settle_r == 2'h0 |=> $stable(refHalved))
      else $error("divider changed after strap capture");
   reset_code_a: assert property (clkEn && settle_r == 2'h1 |=>
      chanCode[0] == ($past(lvlSync_r[1]) ? 16'h8000 : 16'h0000))
      else $error("reset code wrong");
   sync_update_a: assert property (clkEn && settle_r == 2'h0 && syncMode[1] && strobeFall
      && !(writeStrobe && writeChan == 2'h1) |=> chanCode[1] == $past(buffer_r[1]))
      else $error("sync channel missed strobe");
   async_hold_a: assert property (clkEn && settle_r == 2'h0 && !syncMode[2] && !writeStrobe
      |=> $stable(chanCode[2]))
      else $error("async channel moved without write");
   strobe_low_a: assert property (strobeSync_r == 3'h0 |-> !strobeFall)
      else $error("false strobe edge");
   shift_gate_a: assert property (csSync_r[1] && !csRise |=> $stable(shift_r))
      else $error("shift while deselected");
   capture_bit_a: assert property (clkEn && csLow && sclkFall && !csFall
      |=> shift_r[0] == $past(sdiSync_r[1]))
      else $error("data-in bit not captured");
   float_high_a: assert property (!alarmMode && csSync_r[2:1] == 2'b11 ##1 !alarmMode
      |-> !sdoOe)
      else $error("data out driven while deselected");
   alarm_od_a: assert property (alarmMode |=> !sdoOut)
      else $error("alarm pin driven high");
   hold_code_a: assert property (clkEn && settle_r == 2'h0 && !writeStrobe && !strobeFall
      |=> $stable(chanCode[3]))
      else $error("code changed without write");

   write_c: cover property (writeStrobe);
   strobe_c: cover property (strobeFall && syncMode != '0);
   alarm_c: cover property (alarmMode && sdoOe);
endmodule : quad_dac_serial_pin_control
`default_nettype wire

// File: shared/quad_dac_pkg.sv
// constants and carrier types for the four-channel converter pin control
// assumes a single system clock; all pins arrive asynchronously
package quad_dac_pkg;
   localparam int CHANNELS = 4;
   localparam int CODE_WIDTH = 16;
   localparam int FRAME_BITS = 24;
   localparam int CNT_WIDTH = 5;
   // frame layout: [17:16] channel index, [15:0] code
   localparam int FRAME_CHAN_LSB = 16;
   localparam int FRAME_CODE_LSB = 0;
   localparam logic [15:0] ZERO_SCALE_CODE = 16'h0000;
   localparam logic [15:0] MID_SCALE_CODE = 16'h8000;
   // cycles after reset release before the straps are taken (synchroniser fill)
   localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;
   localparam logic [1:0] STRAP_TAKE_CYCLE = 2'h1;

   // strap levels caught once after reset
   typedef struct packed {
      logic gainTwo;
      logic refHalved;
      logic resetMid;
   } strap_type;

   // the three serial input pins as seen from the device
   typedef struct packed {
      logic csB;
      logic sclk;
      logic sdi;
   } serial_pins_type;
endpackage : quad_dac_pkg

// File: verification/host_spi_model.sv
// host controller model that frames serial transfers into the converter
// assumes sclk idles low; sdi changes at rising sclk and is held over the falling edge
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
   // request from the bench
   input wire logic go,
   input wire logic [23:0] frame,
   input wire logic [4:0] nBits,
   // pins and status
   output var quad_dac_pkg::serial_pins_type pins,
   output var logic busy
);
   // idle: deselected, clock still
   initial begin
      pins = 3'b100;
      busy = 1'b0;
   end
   // one frame per rising go, msb first; sdi has no pull so it is inverted once released
   always @(posedge go) begin
      busy = 1'b1;
      #7 pins.csB = 1'b0;
      for (int i = 0; i < nBits; i++) begin
         #40 pins.sclk = 1'b1;
         pins.sdi = frame[23-i];
         #40 pins.sclk = 1'b0;
      end
      #40 pins.csB = 1'b1;
      pins.sdi = ~pins.sdi;
      busy = 1'b0;
   end
endmodule : host_spi_model
`default_nettype wire

// File: verification/tb_quad_dac_serial_pin_control.sv
// self-checking bench for the converter pin control
// assumes the host model drives the serial pins and the alarm pin has a pull-up
`timescale 1ns/1ps
`default_nettype none
module tb_quad_dac_serial_pin_control;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic go = 1'b0, gainStrap = 1'b0, refStrap = 1'b0, levelSel = 1'b0, loadStrobe = 1'b0;
   logic edgeSel = 1'b0, alarmMode = 1'b0, crcFail = 1'b0, refAlarm = 1'b0, clkEn = 1'b1;
   logic [3:0] syncMode = 4'h0;
   logic [23:0] frame = 24'h0;
   logic [4:0] nBits = 5'h18;
   logic busy, sdoOut, sdoOe, gainTwo, refHalved;
   logic [3:0][15:0] chanCode;
   quad_dac_pkg::serial_pins_type pins;
   // open-drain view of the output pin with its pull-up
   wire logic alarmPin = sdoOe ? sdoOut : 1'b1;
   int nMismatch = 0;
   int comparisons = 0;
   initial forever #2 sys_clk = ~sys_clk;
   host_spi_model u_host_spi_model (.go(go), .frame(frame), .nBits(nBits), .pins(pins),
      .busy(busy));
   quad_dac_serial_pin_control u_quad_dac_serial_pin_control (.sys_clk(sys_clk),
      .rst_b(rst_b), .clkEn(clkEn), .serialPins(pins), .sdoOut(sdoOut), .sdoOe(sdoOe),
      .gainStrap(gainStrap), .referenceHalvingStrap(refStrap), .resetLevelSelect(levelSel),
      .loadStrobe(loadStrobe), .outputEdgeSelect(edgeSel), .alarmMode(alarmMode),
      .syncMode(syncMode), .crcFail(crcFail), .refAlarm(refAlarm), .gainTwo(gainTwo),
      .refHalved(refHalved), .chanCode(chanCode));
   // compare and count
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         nMismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wrap_up();
      $display("mismatches %0d comparisons %0d", nMismatch, comparisons);
      if (nMismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc
   // straps taken at reset, later changes ignored
   task automatic t_reset(input logic lvl);
      gainStrap <= lvl; refStrap <= lvl; levelSel <= lvl; rst_b <= 1'b0;
      cyc(2);
      rst_b <= 1'b1;
      cyc(8);
      gainStrap <= ~lvl; refStrap <= ~lvl; levelSel <= ~lvl;
      cyc(8);
      chk("gain", {15'h0, lvl}, {15'h0, gainTwo});
      chk("reference_halving_strap", {15'h0, lvl}, {15'h0, refHalved});
      for (int c = 0; c < 4; c++) chk("reset code", lvl ? 16'h8000 : 16'h0, chanCode[c]);
      $display("reset test level %0b done", lvl);
   endtask : t_reset
   // one frame through the host model, bounded wait
   // sdoExp: msb left in the shift register by the previous frame, shown before the first fall
   task automatic send(input logic [23:0] f, input logic [4:0] n, input logic sdoExp);
      frame <= f; nBits <= n; go <= 1'b1;
      cyc(2);
      go <= 1'b0;
      cyc(20);
      chk("sdo enable in frame", 16'h1, {15'h0, sdoOe});
      chk("sdo first bit", {15'h0, sdoExp}, {15'h0, sdoOut});
      for (int k = 0; k < 1000 && busy; k++) cyc(1);
      if (busy) begin
         nMismatch++;
         wrap_up();
      end
      cyc(10);
      chk("sdo enable idle", 16'h0, {15'h0, sdoOe});
   endtask : send
   // async write with strobe tied low, then a short frame that must be dropped
   task automatic t_write();
      send(24'hfe1234, 5'h18, 1'b0);
      chk("write ch2", 16'h1234, chanCode[2]);
      chk("ch0 kept", 16'h8000, chanCode[0]);
      send(24'h011111, 5'h17, 1'b1);
      chk("short frame", 16'h8000, chanCode[1]);
      $display("write test done");
   endtask : t_write
   // synchronous channel waits for the strobe fall
   task automatic t_sync();
      syncMode <= 4'h8; edgeSel <= 1'b1;
      send(24'h03beef, 5'h18, 1'b0);
      chk("sync held", 16'h8000, chanCode[3]);
      loadStrobe <= 1'b1;
      cyc(5);
      loadStrobe <= 1'b0;
      cyc(8);
      chk("strobe update", 16'hbeef, chanCode[3]);
      chk("async untouched", 16'h1234, chanCode[2]);
      $display("sync test done");
   endtask : t_sync
   // alarm pin follows both sources
   task automatic t_alarm();
      alarmMode <= 1'b1;
      cyc(2);
      clkEn <= 1'b0; crcFail <= 1'b1;
      cyc(4);
      chk("alarm frozen", 16'h1, {15'h0, alarmPin});
      clkEn <= 1'b1;
      cyc(4);
      chk("alarm crc", 16'h0, {15'h0, alarmPin});
      crcFail <= 1'b0;
      cyc(4);
      chk("alarm clear", 16'h1, {15'h0, alarmPin});
      refAlarm <= 1'b1;
      cyc(4);
      chk("alarm ref", 16'h0, {15'h0, alarmPin});
      refAlarm <= 1'b0; alarmMode <= 1'b0;
      $display("alarm test done");
   endtask : t_alarm
   // main sequence
   initial begin
      t_reset(1'b0);
      t_reset(1'b1);
      t_write();
      t_sync();
      t_alarm();
      wrap_up();
   end
endmodule : tb_quad_dac_serial_pin_control
`default_nettype wire
